// *** shared/rsf_pkg.sv ***
package rsf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] RSF_ADDR_STAT = 8'h00;
	localparam logic [7:0] RSF_ADDR_MASK = 8'h04;
	localparam logic [7:0] RSF_ADDR_CTRL = 8'h08;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int RSF_BIT_VZERO = 10;
	localparam int RSF_BIT_POS_MATCH = 9;
	localparam int RSF_BIT_VEL_MATCH = 8;
	localparam int RSF_BIT_EV_ARRIVE = 7;
	localparam int RSF_BIT_EV_STALL = 6;
	localparam int RSF_BIT_EV_STOP_R = 5;
	localparam int RSF_BIT_EV_STOP_L = 4;

	// ----------------------------------------------------------------
	// Control bit positions
	// ----------------------------------------------------------------
	localparam int RSF_CTRL_SW_L_EN = 0;
	localparam int RSF_CTRL_SW_R_EN = 1;
	localparam int RSF_CTRL_STOP_L_EN = 2;
	localparam int RSF_CTRL_STOP_R_EN = 3;
	localparam int RSF_CTRL_SOFT_STOP = 4;
	localparam int RSF_CTRL_STALL_EN = 5;
	localparam int RSF_CTRL_W = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RSF_MASK_RST = 4'hF;
	localparam logic [RSF_CTRL_W-1:0] RSF_CTRL_RST = 6'h00;
	localparam logic [31:0] RSF_RDATA_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rsf_bus_req_t;

	typedef struct packed {
		logic [31:0] current_position;
		logic [31:0] goal_position;
		logic [31:0] velocity;
		logic [31:0] goal_velocity;
		logic ramp_hold;
		logic cmd_dir_right;
	} rsf_motion_t;

endpackage

// *** verilog/rsf_sync2.sv ***
`timescale 1ns/1ps
module rsf_sync2
	import rsf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [1:0] async_in,
	output logic [1:0] sync_out
);

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} rsf_sync_st_t;

	rsf_sync_st_t st_r;
	rsf_sync_st_t st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.sync;

endmodule

// *** verilog/rsf_switch_stop.sv ***
`timescale 1ns/1ps
module rsf_switch_stop
	import rsf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sw_active,
	input wire logic sw_enable,
	input wire logic stop_enable,
	input wire logic moving_toward,
	input wire logic cmd_away,
	input wire logic ramp_hold,
	input wire logic soft_stop,
	output logic stop_flag,
	output logic stop_flag_nxt
);

	typedef struct packed {
		logic flag;
	} rsf_stop_st_t;

	rsf_stop_st_t st_r;
	rsf_stop_st_t st_nxt;
	logic set_cond;
	logic release_cond;

	always_comb begin
		set_cond = sw_active & ~cmd_away & ~ramp_hold;
		release_cond = (ramp_hold | cmd_away) & ~(soft_stop & moving_toward);
		st_nxt = st_r;
		if (!sw_enable || !stop_enable) begin
			st_nxt.flag = 1'b0;
		end else if (set_cond) begin
			st_nxt.flag = 1'b1;
		end else if (release_cond) begin
			st_nxt.flag = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign stop_flag = st_r.flag;
	// Next value lets the parent register its interrupt on the same edge as the flag
	assign stop_flag_nxt = st_nxt.flag;

endmodule

// *** verilog/rsf_status_flags.sv ***
`timescale 1ns/1ps
// Functional notes
// - Bit 10 reads one while present velocity is zero.
// - Bit 9 reads one while current and goal position are equal.
// - Bit 8 reads one while velocity equals the goal velocity.
// - Bit 7 latches when position match rises.
// - Writing one to bit 7 or 6 clears it; zero leaves it.
// - Bit 6 latches a stall halt; reading the status clears it.
// - Clearing the stall halt lets motion resume unless otherwise stopped.
// - Bit 5 shows an active right switch stop condition.
// - Bit 4 shows an active left switch stop condition.
// - Hold mode or reverse command removes a switch stop and its interrupt.
// - Gentle halt keeps a switch stop until motion toward it ends.
// - Disabling switch or stop function clears its flag; motion continues.
// - Arrival, stall and both switch stop flags feed the interrupt output.
module rsf_status_flags
	import rsf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire rsf_bus_req_t bus_req,
	output logic [31:0] rdata_r,
	input wire rsf_motion_t motion,
	input wire logic stall_detect,
	input wire logic ref_l_pin,
	input wire logic ref_r_pin,
	output logic irq_r,
	output logic stall_halt_r,
	output logic stop_l_r,
	output logic stop_r_r
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rdata;
		logic [3:0] mask;
		logic [RSF_CTRL_W-1:0] ctrl;
		logic vzero;
		logic pos_match;
		logic vel_match;
		logic ev_arrive;
		logic ev_stall;
		logic irq;
	} rsf_state_t;

	rsf_state_t st_r;
	rsf_state_t st_nxt;

	logic [1:0] ref_sync;
	logic flag_stop_l;
	logic flag_stop_r;
	logic flag_stop_l_nxt;
	logic flag_stop_r_nxt;
	logic [31:0] status_word;
	logic status_read;
	logic status_write;
	logic vel_neg;
	logic vel_pos;
	logic pos_eq;
	logic [3:0] ev_vec;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_addr);
		addr_hit = (a == ref_addr);
	endfunction

	// Sticky flag: set has priority so a coincident clear never drops an event
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	// ----------------------------------------------------------------
	// Reference switch inputs
	// ----------------------------------------------------------------
	rsf_sync2 u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in({ref_r_pin, ref_l_pin}),
		.sync_out(ref_sync)
	);

	assign vel_neg = motion.velocity[31];
	assign vel_pos = ~motion.velocity[31] & (motion.velocity != 32'h0000_0000);

	// Left switch stops travel in the negative direction
	// left switch stop
	rsf_switch_stop u_stop_l (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sw_active(ref_sync[0]),
		.sw_enable(st_r.ctrl[RSF_CTRL_SW_L_EN]),
		.stop_enable(st_r.ctrl[RSF_CTRL_STOP_L_EN]),
		.moving_toward(vel_neg),
		.cmd_away(motion.cmd_dir_right),
		.ramp_hold(motion.ramp_hold),
		.soft_stop(st_r.ctrl[RSF_CTRL_SOFT_STOP]),
		.stop_flag(flag_stop_l),
		.stop_flag_nxt(flag_stop_l_nxt)
	);

	rsf_switch_stop u_stop_r (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sw_active(ref_sync[1]),
		.sw_enable(st_r.ctrl[RSF_CTRL_SW_R_EN]),
		.stop_enable(st_r.ctrl[RSF_CTRL_STOP_R_EN]),
		.moving_toward(vel_pos),
		.cmd_away(~motion.cmd_dir_right),
		.ramp_hold(motion.ramp_hold),
		.soft_stop(st_r.ctrl[RSF_CTRL_SOFT_STOP]),
		.stop_flag(flag_stop_r),
		.stop_flag_nxt(flag_stop_r_nxt)
	);

	// ----------------------------------------------------------------
	// Status word as software sees it
	// ----------------------------------------------------------------
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[RSF_BIT_VZERO] = st_r.vzero;
		status_word[RSF_BIT_POS_MATCH] = st_r.pos_match;
		status_word[RSF_BIT_VEL_MATCH] = st_r.vel_match;
		status_word[RSF_BIT_EV_ARRIVE] = st_r.ev_arrive;
		status_word[RSF_BIT_EV_STALL] = st_r.ev_stall;
		status_word[RSF_BIT_EV_STOP_R] = flag_stop_r;
		status_word[RSF_BIT_EV_STOP_L] = flag_stop_l;
	end

	assign status_read = bus_req.rd & addr_hit(bus_req.addr, RSF_ADDR_STAT);
	assign status_write = bus_req.wr & addr_hit(bus_req.addr, RSF_ADDR_STAT);
	assign pos_eq = (motion.current_position == motion.goal_position);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;

		st_nxt.vzero = (motion.velocity == 32'h0000_0000);
		st_nxt.pos_match = pos_eq;
		st_nxt.vel_match = (motion.velocity == motion.goal_velocity);

		st_nxt.ev_arrive = sticky(st_r.ev_arrive, pos_eq & ~st_r.pos_match,
			status_write & bus_req.wdata[RSF_BIT_EV_ARRIVE]);

		st_nxt.ev_stall = sticky(st_r.ev_stall,
			stall_detect & st_r.ctrl[RSF_CTRL_STALL_EN],
			status_read | (status_write & bus_req.wdata[RSF_BIT_EV_STALL]));

		// Disabling stall stop drops a pending halt so motion is not stuck
		if (!st_r.ctrl[RSF_CTRL_STALL_EN]) begin
			st_nxt.ev_stall = 1'b0;
		end

		// Register writes
		if (bus_req.wr && addr_hit(bus_req.addr, RSF_ADDR_MASK)) begin
			st_nxt.mask = bus_req.wdata[RSF_BIT_EV_ARRIVE:RSF_BIT_EV_STOP_L];
		end
		if (bus_req.wr && addr_hit(bus_req.addr, RSF_ADDR_CTRL)) begin
			st_nxt.ctrl = bus_req.wdata[RSF_CTRL_W-1:0];
		end

		// Read data valid in the cycle after the strobe only
		st_nxt.rdata = RSF_RDATA_RST;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				RSF_ADDR_STAT: begin
					st_nxt.rdata = status_word;
				end
				RSF_ADDR_MASK: begin
					st_nxt.rdata[RSF_BIT_EV_ARRIVE:RSF_BIT_EV_STOP_L] = st_r.mask;
				end
				RSF_ADDR_CTRL: begin
					st_nxt.rdata[RSF_CTRL_W-1:0] = st_r.ctrl;
				end
				default: begin
					st_nxt.rdata = RSF_RDATA_RST;
				end
			endcase
		end

		// Interrupt from next flag values so it falls on the same edge as the last flag
		// events feed irq
		// level tracks flags
		// Mask also from its next value, so a mask write takes effect on its own edge
		ev_vec = {st_nxt.ev_arrive, st_nxt.ev_stall, flag_stop_r_nxt, flag_stop_l_nxt};
		st_nxt.irq = |(ev_vec & st_nxt.mask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.mask <= RSF_MASK_RST;
			st_r.ctrl <= RSF_CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_r = st_r.rdata;
	assign irq_r = st_r.irq;
	assign stall_halt_r = st_r.ev_stall;
	assign stop_l_r = flag_stop_l;
	assign stop_r_r = flag_stop_r;

endmodule

// *** verification/rsf_host_model.sv ***
`timescale 1ns/1ps
module rsf_host_model
	import rsf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [31:0] rdata_r,
	output rsf_bus_req_t bus_req
);
	// ----------------------------------------------------------------
	// Bus cycles, strobes held for exactly one sampled edge
	// ----------------------------------------------------------------
	initial bus_req = '0;
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 d = rdata_r;
	endtask
endmodule

// *** verification/rsf_status_flags_sva.sv ***
`timescale 1ns/1ps
module rsf_status_flags_chk
	import rsf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire rsf_bus_req_t bus_req,
	input wire logic [31:0] rdata_r,
	input wire rsf_motion_t motion,
	input wire logic stall_detect,
	input wire logic ref_l_pin,
	input wire logic ref_r_pin,
	input wire logic irq_r,
	input wire logic stall_halt_r,
	input wire logic stop_l_r,
	input wire logic stop_r_r
);
	logic rd_st;
	logic wr_st;
	logic wr_ct;
	assign rd_st = bus_req.rd && bus_req.addr == RSF_ADDR_STAT;
	assign wr_st = bus_req.wr && bus_req.addr == RSF_ADDR_STAT;
	assign wr_ct = bus_req.wr && bus_req.addr == RSF_ADDR_CTRL;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	vzero_read_a:
		assert property (rd_st |=> rdata_r[10] == ($past(motion.velocity, 2) == 0))
		else $error("zero velocity bit wrong");
	pos_match_a:
		assert property (rd_st |=> rdata_r[9] == ($past(motion.current_position, 2)
			== $past(motion.goal_position, 2))) else $error("position match bit wrong");
	vel_match_a:
		assert property (rd_st |=> rdata_r[8] == ($past(motion.velocity, 2)
			== $past(motion.goal_velocity, 2))) else $error("velocity match bit wrong");
	stall_rdclr_a:
		assert property (rd_st && !stall_detect |=> !stall_halt_r)
		else $error("stall flag kept after read");
	stall_w1c_a:
		assert property (wr_st && bus_req.wdata[6] && !stall_detect |=> !stall_halt_r)
		else $error("stall flag kept after write one");
	stall_sticky_a:
		assert property (stall_halt_r && !rd_st && !wr_st && !wr_ct && !$past(wr_ct)
			|=> stall_halt_r)
		else $error("stall flag lost");
	stop_bits_a:
		assert property (rd_st |=> rdata_r[6:4] == {$past(stall_halt_r), $past(stop_r_r),
			$past(stop_l_r)}) else $error("event bits differ from flags");
	rdata_idle_a:
		assert property (!bus_req.rd |=> rdata_r == 32'h0) else $error("read data not idle");
endmodule
bind rsf_status_flags rsf_status_flags_chk i_chk (.clk_sys, .reset_n, .bus_req, .rdata_r,
	.motion, .stall_detect, .ref_l_pin, .ref_r_pin, .irq_r, .stall_halt_r, .stop_l_r,
	.stop_r_r);

// *** verification/test_ramp_status_event_flags.sv ***
`timescale 1ns/1ps
module test_ramp_status_event_flags
	import rsf_pkg::*;
;
	logic clk_sys = 0;
	logic reset_n = 0;
	rsf_motion_t motion = '0;
	logic stall_detect = 0;
	logic ref_l_pin = 0;
	logic ref_r_pin = 0;
	rsf_bus_req_t bus_req;
	logic [31:0] rdata_r, d, pos, vel;
	logic irq_r, stall_halt_r, stop_l_r, stop_r_r;
	int num_errors = 0;
	int comparisons = 0;
	integer seed = 32'h5630;
	always #5 clk_sys = ~clk_sys;
	rsf_host_model i_host (.clk_sys(clk_sys), .rdata_r(rdata_r), .bus_req(bus_req));
	rsf_status_flags i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
		.rdata_r(rdata_r), .motion(motion), .stall_detect(stall_detect),
		.ref_l_pin(ref_l_pin), .ref_r_pin(ref_r_pin), .irq_r(irq_r),
		.stall_halt_r(stall_halt_r), .stop_l_r(stop_l_r), .stop_r_r(stop_r_r));
	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] live_bits(input rsf_motion_t m);
		return {21'h0, m.velocity == 0, m.current_position == m.goal_position,
			m.velocity == m.goal_velocity, 8'h0};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic stop_test;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		stop_test;
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		motion.goal_position = 32'h1;
		step(5);
		@(posedge clk_sys) reset_n <= 1;
		i_host.rd(RSF_ADDR_STAT, d);
		chk(d & 32'h700, 32'h500);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			pos = $random(seed);
			vel = i[1] ? 32'h0 : $random(seed);
			motion.current_position <= pos;
			motion.goal_position <= i[0] ? pos : $random(seed);
			motion.velocity <= vel;
			motion.goal_velocity <= i[2] ? vel : $random(seed);
			step(2);
			i_host.rd(RSF_ADDR_STAT, d);
			chk(d & 32'h700, live_bits(motion));
		end
		@(posedge clk_sys) motion.goal_position <= motion.current_position + 1;
		motion.velocity <= 32'h0;
		i_host.wr(RSF_ADDR_STAT, 32'h80);
		chk(irq_r, 0);
		@(posedge clk_sys) motion.goal_position <= motion.current_position;
		step(3);
		chk(irq_r, 1);
		i_host.wr(RSF_ADDR_STAT, 32'h0);
		i_host.rd(RSF_ADDR_STAT, d);
		chk(d[7], 1);
		i_host.wr(RSF_ADDR_MASK, 32'h0);
		chk(irq_r, 0);
		i_host.wr(RSF_ADDR_MASK, 32'hF0);
		i_host.rd(RSF_ADDR_MASK, d);
		chk(d, 32'hF0);
		i_host.wr(RSF_ADDR_STAT, 32'h80);
		chk(irq_r, 0);
		i_host.wr(RSF_ADDR_CTRL, 32'h20);
		@(posedge clk_sys) stall_detect <= 1;
		@(posedge clk_sys) stall_detect <= 0;
		step(2);
		chk({stall_halt_r, irq_r}, 2'b11);
		i_host.rd(RSF_ADDR_STAT, d);
		chk({d[6], stall_halt_r, irq_r}, 3'b100);
		@(posedge clk_sys) stall_detect <= 1;
		i_host.wr(RSF_ADDR_STAT, 32'h40);
		chk(stall_halt_r, 1);
		@(posedge clk_sys) stall_detect <= 0;
		i_host.wr(RSF_ADDR_STAT, 32'h40);
		chk(stall_halt_r, 0);
		i_host.rd(8'h0C, d);
		chk(d, 0);
		@(posedge clk_sys) motion.velocity <= -32'sd5;
		ref_l_pin <= 1;
		i_host.wr(RSF_ADDR_CTRL, 32'h05);
		step(4);
		chk({stop_l_r, irq_r}, 2'b11);
		@(posedge clk_sys) motion.cmd_dir_right <= 1;
		step(2);
		chk({stop_l_r, irq_r}, 2'b00);
		@(posedge clk_sys) motion.cmd_dir_right <= 0;
		step(2);
		chk(stop_l_r, 1);
		i_host.wr(RSF_ADDR_CTRL, 32'h0);
		step(1);
		chk(stop_l_r, 0);
		@(posedge clk_sys) motion.velocity <= 32'sd5;
		motion.cmd_dir_right <= 1;
		ref_r_pin <= 1;
		i_host.wr(RSF_ADDR_CTRL, 32'h1A);
		step(4);
		i_host.rd(RSF_ADDR_STAT, d);
		chk(d[5:4], 2'b10);
		@(posedge clk_sys) motion.ramp_hold <= 1;
		step(2);
		chk(stop_r_r, 1);
		@(posedge clk_sys) motion.velocity <= 32'h0;
		step(2);
		chk({stop_r_r, irq_r}, 2'b00);
		stop_test;
	end
endmodule
